/* core/pin_route_defs.svh */
/*
  Constants for the pin routing and configuration block: widths, field
  positions, fixed pins, reset values and the routed signal count.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef PIN_ROUTE_DEFS_SVH
`define PIN_ROUTE_DEFS_SVH
`define NUM_PINS 32
`define NUM_PORTS_ROUTED 4
`define PORT_WIDTH 8
`define SEL_A_WIDTH 8
`define SEL_B_WIDTH 8
`define SEL_C_WIDTH 2
// Field positions of route_select_a
`define SA_UART0 0
`define SA_SPI 1
`define SA_BUS0 2
`define SA_SYSCLK 3
`define SA_CMP0 4
`define SA_CMP0A 5
`define SA_CMP1 6
`define SA_CMP1A 7
// Field positions of route_select_b
`define SB_PCA_LO 0
`define SB_PCA_HI 2
`define SB_ECI 3
`define SB_T0 4
`define SB_T1 5
// Field positions of route_select_c
`define SC_UART1 0
`define SC_BUS1 1
// Fixed pins of the first serial port
`define UART0_TX_PIN 5'h04
`define UART0_RX_PIN 5'h05
// Reset values
`define INPUT_KIND_RST 32'hFFFFFFFF
`define FIFTH_INPUT_KIND_RST 8'hFF
`define ZERO32 32'h00000000
// Number of routed peripheral signals
`define NUM_SIGS 22
`endif

/* core/pin_route_pkg.sv */
/*
  Types for the pin routing and configuration block.
  Assumes the defs header is on the include path.
*/
`include "pin_route_defs.svh"
package pin_route_pkg;
  // Peripheral signals in fixed priority order
  typedef enum {
    SIG_TX0, SIG_RX0, SIG_SCK, SIG_MISO, SIG_MOSI, SIG_NSS, SIG_SDA0, SIG_SCL0,
    SIG_CP0, SIG_CP0A, SIG_CP1, SIG_CP1A, SIG_SYSCLK, SIG_CEX0, SIG_CEX1,
    SIG_CEX2, SIG_CEX3, SIG_CEX4, SIG_ECI, SIG_T0, SIG_T1, SIG_TX1
  } sig_type;
  typedef logic [`NUM_PINS-1:0] pin_vec_type;
endpackage

/* core/pin_route.sv */
/*
  Pin configuration and routing-enable logic for four routed ports and one
  fixed general-purpose port. Peripherals on one side, pin cells on the other.
  Assumes configuration ports are steady register outputs from the core and
  the pin pad resolves drive from the data and enable signals given here.
*/
`timescale 1ns/1ps
`include "pin_route_defs.svh"
module pin_route
  import pin_route_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Configuration from the core
  input wire logic [`NUM_PINS-1:0] pin_input_kind_bits,
  input wire logic [`NUM_PINS-1:0] pin_driver_kind_bits,
  input wire logic [`NUM_PINS-1:0] route_skip_bits,
  input wire logic [`NUM_PINS-1:0] port_latch,
  input wire logic [`SEL_A_WIDTH-1:0] route_select_a,
  input wire logic [`SEL_B_WIDTH-1:0] route_select_b,
  input wire logic [`SEL_C_WIDTH-1:0] route_select_c,
  input wire logic route_matrix_on,
  input wire logic pullup_off,
  // Fifth port configuration
  input wire logic [`PORT_WIDTH-1:0] fifth_input_kind_bits,
  input wire logic [`PORT_WIDTH-1:0] fifth_driver_kind_bits,
  input wire logic [`PORT_WIDTH-1:0] fifth_port_latch,
  // Peripheral output data and driver requests, in priority order
  input wire logic [`NUM_SIGS-1:0] periph_out,
  input wire logic [`NUM_SIGS-1:0] periph_oe,
  // Peripheral input data from pins
  output logic [`NUM_SIGS-1:0] periph_in,
  // Routed port pins
  input wire logic [`NUM_PINS-1:0] pin_in,
  output logic [`NUM_PINS-1:0] pin_out,
  output logic [`NUM_PINS-1:0] pin_oe,
  output logic [`NUM_PINS-1:0] pin_pullup,
  output logic [`NUM_PINS-1:0] pin_rx_on,
  output logic [`NUM_PINS-1:0] pin_read,
  // Fifth port pins
  input wire logic [`PORT_WIDTH-1:0] fifth_pin_in,
  output logic [`PORT_WIDTH-1:0] fifth_pin_out,
  output logic [`PORT_WIDTH-1:0] fifth_pin_oe,
  output logic [`PORT_WIDTH-1:0] fifth_pin_pullup,
  output logic [`PORT_WIDTH-1:0] fifth_pin_read
);

  // Registered copies of configuration
  logic [`NUM_PINS-1:0] in_kind_q, drv_kind_q, skip_q, latch_q;
  logic [`SEL_A_WIDTH-1:0] sel_a_q;
  logic [`SEL_B_WIDTH-1:0] sel_b_q;
  logic [`SEL_C_WIDTH-1:0] sel_c_q;
  logic route_on_q, pu_off_q;
  logic [`PORT_WIDTH-1:0] f_in_kind_q, f_drv_kind_q, f_latch_q;
  // Routing result
  logic [`NUM_SIGS-1:0] sig_en;
  logic [4:0] sig_pin [`NUM_SIGS];
  logic [4:0] sig_pin_d [`NUM_SIGS];
  logic [`NUM_SIGS-1:0] sig_placed;
  logic [`NUM_PINS-1:0] pin_taken;
  logic [`NUM_PINS-1:0] pin_od;
  logic [`NUM_PINS-1:0] drv_d, out_d, pu_d, rx_d;
  logic [`PORT_WIDTH-1:0] f_oe_d, f_pu_d;

  // Lowest set bit of a free-pin vector
  function automatic logic [4:0] lowest(input logic [`NUM_PINS-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = `NUM_PINS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Weak pull-up for a pin: open-drain, digital, not driving low
  function automatic logic pull(input logic od, input logic dig, input logic drv,
                                input logic val, input logic puoff);
    return dig && od && !puoff && !(drv && !val);
  endfunction

  // Configuration capture, visible the next cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      in_kind_q <= `INPUT_KIND_RST;
      drv_kind_q <= `ZERO32;
      skip_q <= `ZERO32;
      latch_q <= `INPUT_KIND_RST;
      sel_a_q <= 8'h00;
      sel_b_q <= 8'h00;
      sel_c_q <= 2'h0;
      route_on_q <= 1'b0;
      pu_off_q <= 1'b0;
      f_in_kind_q <= `FIFTH_INPUT_KIND_RST;
      f_drv_kind_q <= 8'h00;
      f_latch_q <= 8'hFF;
    end else begin
      in_kind_q <= pin_input_kind_bits;
      drv_kind_q <= pin_driver_kind_bits;
      skip_q <= route_skip_bits;
      latch_q <= port_latch;
      sel_a_q <= route_select_a;
      sel_b_q <= route_select_b;
      sel_c_q <= route_select_c;
      route_on_q <= route_matrix_on;
      pu_off_q <= pullup_off;
      f_in_kind_q <= fifth_input_kind_bits;
      f_drv_kind_q <= fifth_driver_kind_bits;
      f_latch_q <= fifth_port_latch;
    end
  end

  // Signal enables from selections; pairs enabled together
  always_comb begin
    sig_en = '0;
    sig_en[SIG_TX0] = sel_a_q[`SA_UART0];
    sig_en[SIG_RX0] = sel_a_q[`SA_UART0];
    sig_en[SIG_SCK] = sel_a_q[`SA_SPI];
    sig_en[SIG_MISO] = sel_a_q[`SA_SPI];
    sig_en[SIG_MOSI] = sel_a_q[`SA_SPI];
    sig_en[SIG_NSS] = sel_a_q[`SA_SPI];
    sig_en[SIG_SDA0] = sel_a_q[`SA_BUS0];
    sig_en[SIG_SCL0] = sel_a_q[`SA_BUS0];
    sig_en[SIG_CP0] = sel_a_q[`SA_CMP0];
    sig_en[SIG_CP0A] = sel_a_q[`SA_CMP0A];
    sig_en[SIG_CP1] = sel_a_q[`SA_CMP1];
    sig_en[SIG_CP1A] = sel_a_q[`SA_CMP1A];
    sig_en[SIG_SYSCLK] = sel_a_q[`SA_SYSCLK];
    for (int k = 0; k < 5; k++) begin
      sig_en[SIG_CEX0 + k] = (sel_b_q[`SB_PCA_HI:`SB_PCA_LO] > 3'(k)) &&
                             (sel_b_q[`SB_PCA_HI:`SB_PCA_LO] < 3'h6);
    end
    sig_en[SIG_ECI] = sel_b_q[`SB_ECI];
    sig_en[SIG_T0] = sel_b_q[`SB_T0];
    sig_en[SIG_T1] = sel_b_q[`SB_T1];
    sig_en[SIG_TX1] = sel_c_q[`SC_UART1];
  end

  // Priority allocation: fixed serial pins first, then lowest free pins
  always_comb begin
    logic [`NUM_PINS-1:0] taken;
    taken = skip_q;
    if (sig_en[SIG_TX0]) begin
      taken[`UART0_TX_PIN] = 1'b1;
      taken[`UART0_RX_PIN] = 1'b1;
    end
    sig_placed = '0;
    for (int s = 0; s < `NUM_SIGS; s++) begin
      sig_pin_d[s] = 5'h00;
      if (s == SIG_TX0) begin
        sig_pin_d[s] = `UART0_TX_PIN;
        sig_placed[s] = sig_en[s];
      end else if (s == SIG_RX0) begin
        sig_pin_d[s] = `UART0_RX_PIN;
        sig_placed[s] = sig_en[s];
      end else if (sig_en[s] && (~taken != '0)) begin
        sig_pin_d[s] = lowest(~taken);
        sig_placed[s] = 1'b1;
        taken[sig_pin_d[s]] = 1'b1;
      end
    end
    pin_taken = taken & ~skip_q;
  end
  assign sig_pin = sig_pin_d;

  // Pin drive and pull-up per routed pin
  always_comb begin
    drv_d = '0;
    out_d = latch_q;
    pin_od = ~drv_kind_q;
    for (int s = 0; s < `NUM_SIGS; s++) begin
      if (sig_placed[s] && route_on_q) begin
        out_d[sig_pin[s]] = periph_out[s];
        drv_d[sig_pin[s]] = periph_oe[s];
        if (s == SIG_SDA0 || s == SIG_SCL0) begin
          pin_od[sig_pin[s]] = 1'b1;
        end
      end
    end
    for (int p = 0; p < `NUM_PINS; p++) begin
      if (!pin_taken[p]) begin
        drv_d[p] = pin_od[p] ? !latch_q[p] : 1'b1;
      end
      if (pin_od[p] && out_d[p]) begin
        drv_d[p] = 1'b0;
      end
      if (!route_on_q || !in_kind_q[p]) begin
        drv_d[p] = 1'b0;
      end
      pu_d[p] = pull(pin_od[p], in_kind_q[p], drv_d[p], out_d[p], pu_off_q);
      rx_d[p] = in_kind_q[p];
    end
  end

  // Fifth port: plain I/O regardless of routing
  always_comb begin
    for (int p = 0; p < `PORT_WIDTH; p++) begin
      f_oe_d[p] = f_in_kind_q[p] && (f_drv_kind_q[p] || !f_latch_q[p]);
      f_pu_d[p] = pull(!f_drv_kind_q[p], f_in_kind_q[p], f_oe_d[p], f_latch_q[p], pu_off_q);
    end
  end

  // Registered pin outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_out <= `INPUT_KIND_RST;
      pin_oe <= `ZERO32;
      pin_pullup <= `INPUT_KIND_RST;
      pin_rx_on <= `INPUT_KIND_RST;
      fifth_pin_out <= 8'hFF;
      fifth_pin_oe <= 8'h00;
      fifth_pin_pullup <= 8'hFF;
    end else begin
      pin_out <= out_d;
      pin_oe <= drv_d;
      pin_pullup <= pu_d;
      pin_rx_on <= rx_d;
      fifth_pin_out <= f_latch_q;
      fifth_pin_oe <= f_oe_d;
      fifth_pin_pullup <= f_pu_d;
    end
  end

  // Input paths: receivers gated off on analog pins
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_read <= `ZERO32;
      fifth_pin_read <= 8'h00;
      periph_in <= '0;
    end else begin
      pin_read <= pin_in & in_kind_q;
      fifth_pin_read <= fifth_pin_in & f_in_kind_q;
      for (int s = 0; s < `NUM_SIGS; s++) begin
        periph_in[s] <= sig_placed[s] && route_on_q && pin_in[sig_pin[s]] &&
                        in_kind_q[sig_pin[s]];
      end
    end
  end

  property p_route_off;
    @(posedge mclk) disable iff (rst) !route_on_q |=> pin_oe == '0;
  endproperty
  a_route_off: assert property (p_route_off) else $error("drive while routing off");
  property p_analog;
    @(posedge mclk) disable iff (rst)
      !in_kind_q[0] |=> !pin_oe[0] && !pin_pullup[0] && !pin_rx_on[0];
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin active");
  property p_low_no_pull;
    @(posedge mclk) disable iff (rst) pin_oe[3] && !pin_out[3] |-> !pin_pullup[3];
  endproperty
  a_low_no_pull: assert property (p_low_no_pull) else $error("pull-up on low");
  property p_pushpull;
    @(posedge mclk) disable iff (rst)
      drv_kind_q[1] && !sig_placed[SIG_SDA0] && !sig_placed[SIG_SCL0] |=> !pin_pullup[1];
  endproperty
  a_pushpull: assert property (p_pushpull) else $error("pull-up on push-pull");
  property p_fixed_uart;
    @(posedge mclk) disable iff (rst)
      sig_en[SIG_TX0] |-> sig_pin[SIG_TX0] == 5'h04 && sig_pin[SIG_RX0] == 5'h05;
  endproperty
  a_fixed_uart: assert property (p_fixed_uart) else $error("serial pins moved");
  property p_skip;
    @(posedge mclk) disable iff (rst) sig_placed[SIG_SCK] |-> !skip_q[sig_pin[SIG_SCK]];
  endproperty
  a_skip: assert property (p_skip) else $error("skipped pin used");
  property p_bus_od;
    @(posedge mclk) disable iff (rst)
      route_on_q && sig_placed[SIG_SDA0] && periph_out[SIG_SDA0] |=>
        !pin_oe[$past(sig_pin[SIG_SDA0])];
  endproperty
  a_bus_od: assert property (p_bus_od) else $error("bus pin driven high");
  property p_reset_digital;
    @(posedge mclk) $fell(rst) |-> in_kind_q == `INPUT_KIND_RST;
  endproperty
  a_reset_digital: assert property (p_reset_digital) else $error("reset not digital");
  c_route: cover property (@(posedge mclk) route_on_q && sig_placed[SIG_SDA0]);
  c_analog: cover property (@(posedge mclk) !in_kind_q[2]);
  c_fifth: cover property (@(posedge mclk) fifth_pin_oe != 8'h00);
endmodule // pin_route

/* test/pin_board.sv */
/*
  Board model for the pads: resolves each pad from the block's drive,
  its weak pull-up and an optional external driver.
  Assumes the bench supplies the external drive and the block clock.
*/
`timescale 1ns/1ps
module pin_board #(
  parameter int W = 32
) (
  // Clock
  input wire logic mclk,
  // Block side of the pads
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe,
  input wire logic [W-1:0] pad_pu,
  // External drivers on the board
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  // Resolved pad level
  output logic [W-1:0] pad_lvl
);
  logic [W-1:0] float_q = '0;
  // A floating pad flips every cycle so that no stale level passes
  always_ff @(posedge mclk) begin
    float_q <= ~float_q;
  end
  // Block drive wins, then a strong board driver, then the pull-up
  assign pad_lvl = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
    | (~pad_oe & ~ext_en & (pad_pu | float_q));
endmodule // pin_board

/* test/tb_port_pin_config_and_routing_enable.sv */
/*
  Self-checking bench for the pin routing block with board pad models.
  Assumes the package and defs header are compiled first.
*/
`timescale 1ns/1ps
module tb_port_pin_config_and_routing_enable;
  import pin_route_pkg::*;
  typedef struct {int k; logic [31:0] e; logic [31:0] m;} note_type;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] ik, dk, sk, lt, ev, en, pout, poe_o, ppu, prx, prd, pin;
  logic [7:0] sa, sb, fik, fdk, flt, fev, fen, fout, foe, fpu, frd, fpin;
  logic [1:0] sc;
  logic mon, puo;
  logic [21:0] po, poe, pi;
  int fail_count = 0;
  int checked = 0;
  note_type notes[$];
  event look;
  logic [31:0] skt[3] = '{32'h00000000, 32'h00000001, 32'h0000000F};
  int sdat[3] = '{0, 1, 6};
  // Clock of 4 ns
  always #2 mclk = ~mclk;
  pin_route pin_route_inst (
    .mclk(mclk), .rst(rst), .pin_input_kind_bits(ik), .pin_driver_kind_bits(dk),
    .route_skip_bits(sk), .port_latch(lt), .route_select_a(sa), .route_select_b(sb),
    .route_select_c(sc), .route_matrix_on(mon), .pullup_off(puo),
    .fifth_input_kind_bits(fik), .fifth_driver_kind_bits(fdk), .fifth_port_latch(flt),
    .periph_out(po), .periph_oe(poe), .periph_in(pi), .pin_in(pin), .pin_out(pout),
    .pin_oe(poe_o), .pin_pullup(ppu), .pin_rx_on(prx), .pin_read(prd),
    .fifth_pin_in(fpin), .fifth_pin_out(fout), .fifth_pin_oe(foe),
    .fifth_pin_pullup(fpu), .fifth_pin_read(frd)
  );
  pin_board #(.W(32)) pin_board_inst (
    .mclk(mclk), .pad_out(pout), .pad_oe(poe_o), .pad_pu(ppu), .ext_val(ev),
    .ext_en(en), .pad_lvl(pin)
  );
  pin_board #(.W(8)) fifth_board_inst (
    .mclk(mclk), .pad_out(fout), .pad_oe(foe), .pad_pu(fpu), .ext_val(fev),
    .ext_en(fen), .pad_lvl(fpin)
  );
  // Note one expected vector of result kind k under mask m
  task automatic expect_v(input int k, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{k, e, m});
  endtask
  // Two edges out, one edge back, two spare, then sample at a falling edge
  task automatic settle();
    repeat (5) @(posedge mclk);
    @(negedge mclk);
  endtask
  // Plain port outcome for the present settings with routing on
  task automatic gpio_expect();
    logic [31:0] oe;
    oe = ik & (dk | ~lt);
    expect_v(0, oe, '1);
    expect_v(1, lt, oe);
    expect_v(2, ~dk & ik & lt & {32{~puo}}, '1);
    expect_v(3, ik, '1);
    expect_v(4, (lt & (dk | ~lt)) | (en & ev), ik);
  endtask
  // Fifth port, all digital, follows its own latch and driver kind and the shared pull-up disable only
  task automatic fifth_expect();
    expect_v(6, {24'h000000, fdk | ~flt}, 32'h000000FF);
    expect_v(7, {24'h000000, flt}, {24'h000000, fdk | ~flt});
    expect_v(8, {24'h000000, ~fdk & flt & {8{~puo}}}, 32'h000000FF);
    expect_v(9, {24'h000000, flt}, {24'h000000, fdk | ~flt | {8{~puo}}});
  endtask
  // Compare every waiting note with the outputs when a sample is taken
  always @(look) begin
    note_type n;
    logic [31:0] g;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.k)
        0: g = poe_o;
        1: g = pout;
        2: g = ppu;
        3: g = prx;
        4: g = prd;
        5: g = {10'h000, pi};
        6: g = {24'h000000, foe};
        8: g = {24'h000000, fpu};
        9: g = {24'h000000, frd};
        default: g = {24'h000000, fout};
      endcase
      checked++;
      if ((g & n.m) !== (n.e & n.m)) begin
        fail_count++;
        $display("BAD %0t kind %0d got %h want %h", $time, n.k, g & n.m, n.e & n.m);
      end
    end
  end
  // Verdict and end of run
  task automatic summarize();
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog: the tests need well under 1000 cycles
  initial begin
    #20000;
    fail_count++;
    summarize();
  end
  // Main sequence
  initial begin
    int s;
    logic [31:0] m;
    void'($urandom(93584));
    {ik, lt, dk, sk, ev, en} = {64'hFFFFFFFF_FFFFFFFF, 128'h0};
    {sa, sb, fev, fen, fdk} = 40'h0;
    {fik, flt, sc, mon, puo, po, poe} = {16'hFFFF, 48'h0};
    // Drivers stay off in reset even with routing requested
    dk = $urandom;
    lt = $urandom;
    mon = 1'b1;
    repeat (2) @(negedge mclk);
    expect_v(0, 32'h00000000, '1);
    expect_v(3, '1, '1);
    ->look;
    @(negedge mclk);
    rst = 1'b0;
    // Routing off: selections and latches must not turn on any routed pin driver
    mon = 1'b0;
    {sc, sa, sb, fdk, flt} = 34'($urandom);
    dk = '1;
    settle();
    expect_v(0, 32'h00000000, '1);
    expect_v(3, '1, '1);
    fifth_expect();
    ->look;
    sc = 2'h0;
    // Routing on with random plain port settings
    for (int i = 0; i < 8; i++) begin
      ik = $urandom;
      dk = $urandom;
      lt = $urandom;
      {sa, sb, fdk, flt} = {16'h0000, 16'($urandom)};
      puo = 1'($urandom);
      en = ~dk & lt;
      ev = $urandom;
      @(negedge mclk);
      mon = 1'b1;
      settle();
      gpio_expect();
      fifth_expect();
      ->look;
    end
    // First serial port and first bus placed around skipped pins
    for (int j = 0; j < 3; j++) begin
      s = sdat[j];
      mon = 1'b0;
      {ik, dk, lt, puo} = {96'hFFFFFFFF_FFFFFFFF_FFFFFFFF, 1'b0};
      sk = skt[j];
      ik = ~sk;
      sa = 8'h05;
      sb = 8'h00;
      ev = $urandom;
      ev[s + 1] = 1'b0;
      en = (32'h1 << 5) | (32'h1 << (s + 1));
      poe = (22'h1 << SIG_TX0) | (22'h1 << SIG_SDA0) | (22'h1 << SIG_SCL0);
      po = (22'(ev[3]) << SIG_TX0) | (22'h1 << SIG_SCL0) | (22'(j == 1) << SIG_SDA0);
      @(negedge mclk);
      mon = 1'b1;
      settle();
      m = (32'h3 << 4) | (32'h3 << s);
      expect_v(0, (32'h1 << 4) | (32'(j != 1) << s), m);
      m = (32'h1 << 4) | (32'h1 << s);
      expect_v(1, (32'(ev[3]) << 4) | (32'(j == 1) << s), m);
      expect_v(2, (32'h2 << s) | (32'(j == 1) << s), 32'h3 << s);
      expect_v(3, ~sk, '1);
      m = (32'h1 << SIG_RX0) | (32'h1 << SIG_SCL0);
      expect_v(5, 32'(ev[5]) << SIG_RX0, m);
      ->look;
    end
    // SPI, timer, counter and second serial signals around two skipped pins
    mon = 1'b0;
    {ik, dk, lt, sk} = {96'hFFFFFFFF_FFFFFFFF_FFFFFFFF, 32'h00000005};
    {sa, sb, sc, en, puo} = {8'h02, 8'h22, 2'h1, 32'h00000000, 1'b0};
    po = 22'($urandom);
    poe = '1;
    @(negedge mclk);
    mon = 1'b1;
    settle();
    m = {22'h3FFFFF, po[21], po[20], po[14], po[13], po[5:3], 1'b1, po[2], 1'b1};
    expect_v(0, '1, '1);
    expect_v(1, m, '1);
    expect_v(2, '0, '1);
    expect_v(4, m, '1);
    expect_v(5, {10'h000, po & 22'h30603C}, '1);
    ->look;
    // Let the compare process take the last notes before the verdict
    @(negedge mclk);
    summarize();
  end
endmodule // tb_port_pin_config_and_routing_enable
